//--- shared/scpars_defines.vh
`ifndef SCPARS_DEFINES_VH
`define SCPARS_DEFINES_VH

// ****************************************************************
// Characters; space and P compared after folding to upper case
// ****************************************************************
`define SCP_CH_SPACE   8'h20
`define SCP_CH_PASS    8'h50
`define SCP_CH_LOW_A   8'h61
`define SCP_CH_LOW_Z   8'h7A
`define SCP_CASE_BIT   8'h20

// ****************************************************************
// Code keywords, first character in the most significant byte
// ****************************************************************
`define SCP_KW_READ    32'h5245_4144
`define SCP_KW_WRITE   40'h57_5249_5445
`define SCP_KW_CMD     24'h43_4D44
`define SCP_LEN_READ   4'h4
`define SCP_LEN_WRITE  4'h5
`define SCP_LEN_CMD    4'h3

// ****************************************************************
// Message classes
// ****************************************************************
`define SCP_CLS_NONE   2'h0
`define SCP_CLS_READ   2'h1
`define SCP_CLS_WRITE  2'h2
`define SCP_CLS_CMD    2'h3

// ****************************************************************
// Field limits
// ****************************************************************
`define SCP_PW_MAX     7
`define SCP_CODE_MAX   8

`endif

//--- hdl/scpars_parser.v
`include "scpars_defines.vh"

module scpars_parser #(
	parameter PW_MAX   = `SCP_PW_MAX,
	parameter CODE_MAX = `SCP_CODE_MAX
) (
	input  wire        clk,
	input  wire        rst,
	input  wire        sel_modem,
	input  wire        modem_rsp,
	input  wire        rx_valid,
	input  wire [7:0]  rx_data,
	input  wire        rx_last,
	input  wire [2:0]  cfg_pw_len,
	input  wire [55:0] cfg_pw,
	output reg         modem_found_q,
	output reg         par_valid_q,
	output reg  [7:0]  par_data_q,
	output reg         msg_done_q,
	output reg  [1:0]  msg_class_q,
	output reg         msg_ok_q,
	output reg         msg_pw_given_q,
	output reg  [63:0] code_word_q,
	output reg  [3:0]  code_len_q
);

	// ****************************************************************
	// Parser states
	// ****************************************************************
	localparam [2:0] S_FIRST = 3'h0;
	localparam [2:0] S_PW    = 3'h1;
	localparam [2:0] S_GAP   = 3'h2;
	localparam [2:0] S_CODE  = 3'h3;
	localparam [2:0] S_PARM  = 3'h4;
	localparam [2:0] S_END   = 3'h5;

	reg [2:0]  state_q;
	reg [55:0] pw_q;
	reg [2:0]  pw_cnt_q;
	reg        pw_long_q;
	reg        pw_given_q;
	reg [63:0] code_q;
	reg [3:0]  code_cnt_q;
	reg        code_long_q;
	reg        par_started_q;
	reg [1:0]  cls;
	reg        pw_match;

	wire [7:0] ch;
	wire       take;
	wire       is_sp;

	// Fold lower-case letters onto upper case
	function [7:0] up;
		input [7:0] c;
		begin
			if (c >= `SCP_CH_LOW_A && c <= `SCP_CH_LOW_Z)
				up = c & ~`SCP_CASE_BIT;
			else
				up = c;
		end
	endfunction

	// Case-blind compare of the supplied password with the stored one
	function pw_eq;
		input [55:0] got;
		input [2:0]  got_len;
		input [55:0] stored;
		input [2:0]  stored_len;
		integer i;
		begin
			pw_eq = (got_len == stored_len);
			for (i = 0; i < 7; i = i + 1) begin
				if (i < stored_len &&
				    up(got[8*i +: 8]) != up(stored[8*i +: 8]))
					pw_eq = 1'b0;
			end
		end
	endfunction

	assign ch    = up(rx_data);
	assign is_sp = (ch == `SCP_CH_SPACE);
	// Bytes are only ours while the serial port is given to the modem
	assign take  = rx_valid && sel_modem && state_q != S_END;

	// Classify the code word once the message has been collected
	always @* begin
		cls = `SCP_CLS_NONE;
		if (!code_long_q) begin
			if (code_cnt_q == `SCP_LEN_READ &&
			    code_q[31:0] == `SCP_KW_READ)
				cls = `SCP_CLS_READ;
			else if (code_cnt_q == `SCP_LEN_WRITE &&
			         code_q[39:0] == `SCP_KW_WRITE)
				cls = `SCP_CLS_WRITE;
			else if (code_cnt_q == `SCP_LEN_CMD &&
			         code_q[23:0] == `SCP_KW_CMD)
				cls = `SCP_CLS_CMD;
		end
		// An overlong password can never match a seven-character store
		pw_match = pw_given_q && !pw_long_q &&
		           pw_eq(pw_q, pw_cnt_q, cfg_pw, cfg_pw_len);
	end

	// ****************************************************************
	// Modem presence
	// ****************************************************************
	// Any answer from the modem marks it found; dropped with the port
	always @(posedge clk or posedge rst) begin
		if (rst)
			modem_found_q <= 1'b0;
		else if (!sel_modem)
			modem_found_q <= 1'b0;
		else if (modem_rsp)
			modem_found_q <= 1'b1;
	end

	// ****************************************************************
	// Field splitter
	// ****************************************************************
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q        <= S_FIRST;
			pw_q           <= 56'h0000_0000_0000_00;
			pw_cnt_q       <= 3'h0;
			pw_long_q      <= 1'b0;
			pw_given_q     <= 1'b0;
			code_q         <= 64'h0000_0000_0000_0000;
			code_cnt_q     <= 4'h0;
			code_long_q    <= 1'b0;
			par_started_q  <= 1'b0;
			par_valid_q    <= 1'b0;
			par_data_q     <= 8'h00;
			msg_done_q     <= 1'b0;
			msg_class_q    <= `SCP_CLS_NONE;
			msg_ok_q       <= 1'b0;
			msg_pw_given_q <= 1'b0;
			code_word_q    <= 64'h0000_0000_0000_0000;
			code_len_q     <= 4'h0;
		end else begin
			par_valid_q <= 1'b0;
			msg_done_q  <= 1'b0;
			if (state_q == S_END) begin
				// One closing cycle: verdict out and clear for next text on the same edge
				msg_done_q     <= 1'b1;
				msg_class_q    <= cls;
				msg_pw_given_q <= pw_given_q;
				code_word_q    <= code_q;
				code_len_q     <= code_cnt_q;
				case (cls)
				`SCP_CLS_READ:
					msg_ok_q <= 1'b1;
				`SCP_CLS_WRITE, `SCP_CLS_CMD:
					msg_ok_q <= (cfg_pw_len == 3'h0) ||
					            pw_match;
				default:
					msg_ok_q <= 1'b0;
				endcase
				state_q       <= S_FIRST;
				pw_q          <= 56'h0000_0000_0000_00;
				pw_cnt_q      <= 3'h0;
				pw_long_q     <= 1'b0;
				pw_given_q    <= 1'b0;
				code_q        <= 64'h0000_0000_0000_0000;
				code_cnt_q    <= 4'h0;
				code_long_q   <= 1'b0;
				par_started_q <= 1'b0;
			end else if (take) begin
				case (state_q)
				S_FIRST: begin
					if (is_sp)
						state_q <= S_FIRST;
					else if (ch == `SCP_CH_PASS) begin
						state_q    <= S_PW;
						pw_given_q <= 1'b1;
					end else begin
						state_q    <= S_CODE;
						code_q     <= {code_q[55:0], ch};
						code_cnt_q <= 4'h1;
					end
				end
				S_PW: begin
					if (is_sp)
						state_q <= S_GAP;
					else if (pw_cnt_q < PW_MAX) begin
						pw_q[8*pw_cnt_q +: 8] <= ch;
						pw_cnt_q <= pw_cnt_q + 3'h1;
					end else
						pw_long_q <= 1'b1;
				end
				S_GAP: begin
					if (!is_sp) begin
						state_q    <= S_CODE;
						code_q     <= {code_q[55:0], ch};
						code_cnt_q <= 4'h1;
					end
				end
				S_CODE: begin
					if (is_sp)
						state_q <= S_PARM;
					else if (code_cnt_q < CODE_MAX) begin
						code_q     <= {code_q[55:0], ch};
						code_cnt_q <= code_cnt_q + 4'h1;
					end else
						code_long_q <= 1'b1;
				end
				S_PARM: begin
					// Leading spaces dropped, inner ones kept for the user
					if (!is_sp || par_started_q) begin
						par_valid_q   <= 1'b1;
						par_data_q    <= ch;
						par_started_q <= 1'b1;
					end
				end
				default:
					state_q <= S_FIRST;
				endcase
				if (rx_last)
					state_q <= S_END;
			end
		end
	end

endmodule // scpars_parser

//--- verif/scpars_monitor.sv
`include "scpars_defines.vh"
module scpars_monitor (
	input wire       clk,
	input wire       rst,
	input wire       sel_modem,
	input wire       modem_rsp,
	input wire       rx_valid,
	input wire       rx_last,
	input wire [2:0] cfg_pw_len,
	input wire       par_valid_q,
	input wire       msg_done_q,
	input wire [1:0] msg_class_q,
	input wire       msg_ok_q,
	input wire       msg_pw_given_q,
	input wire       modem_found_q
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Closing byte of a message, taken while the port is set for the modem
	sequence s_last_byte;
		!(rx_valid && rx_last) ##1 (rx_valid && rx_last && sel_modem);
	endsequence
	a_done_after_last: assert property (s_last_byte |-> ##2 msg_done_q)
		else $error("no verdict after last byte");
	a_done_has_cause: assert property (msg_done_q |->
		$past(rx_valid && rx_last && sel_modem, 2))
		else $error("verdict without last byte");
	a_done_single: assert property (msg_done_q |=> !msg_done_q)
		else $error("verdict longer than one cycle");
	a_par_cause: assert property (par_valid_q |->
		$past(rx_valid && sel_modem))
		else $error("parameter without taken byte");
	a_verdict_holds: assert property (!msg_done_q |->
		$stable(msg_class_q) && $stable(msg_ok_q))
		else $error("verdict changed between messages");
	a_read_open: assert property (msg_done_q &&
		msg_class_q == `SCP_CLS_READ |-> msg_ok_q)
		else $error("read refused");
	// Verdict is formed one edge before the pulse, so use that setting
	a_nopw_open: assert property (msg_done_q &&
		$past(cfg_pw_len) == 3'h0 &&
		msg_class_q != `SCP_CLS_NONE |-> msg_ok_q)
		else $error("refused with no password stored");
	a_missing_pw: assert property (msg_done_q &&
		$past(cfg_pw_len) != 3'h0 &&
		msg_class_q[1] && !msg_pw_given_q |-> !msg_ok_q)
		else $error("accepted without password");
	a_unknown_out: assert property (msg_done_q &&
		msg_class_q == `SCP_CLS_NONE |-> !msg_ok_q)
		else $error("unknown code accepted");
	a_modem_seen: assert property (sel_modem && modem_rsp ##1
		sel_modem |-> modem_found_q)
		else $error("modem answer missed");
	a_modem_off: assert property (!sel_modem |=> !modem_found_q)
		else $error("modem flag kept while port off");
endmodule // scpars_monitor

bind scpars_parser scpars_monitor scpars_monitor_inst (.clk(clk), .rst(rst),
	.sel_modem(sel_modem), .modem_rsp(modem_rsp), .rx_valid(rx_valid),
	.rx_last(rx_last), .cfg_pw_len(cfg_pw_len), .par_valid_q(par_valid_q),
	.msg_done_q(msg_done_q), .msg_class_q(msg_class_q), .msg_ok_q(msg_ok_q),
	.msg_pw_given_q(msg_pw_given_q), .modem_found_q(modem_found_q));

//--- verif/scpars_modem_model.sv
module scpars_modem_model (
	input  wire       clk,
	output reg        rx_valid,
	output reg  [7:0] rx_data,
	output reg        rx_last
);
	timeunit 1ns;
	timeprecision 1ns;
	// Line starts quiet
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_last = 1'b0;
	end
	// One byte a cycle; idle data inverted so a stale byte never matches
	task send(input string m);
		for (int i = 0; i < m.len(); i++) begin
			@(negedge clk);
			rx_valid = 1'b1;
			rx_data = m[i];
			rx_last = (i == m.len() - 1);
		end
		@(negedge clk);
		rx_valid = 1'b0;
		rx_last = 1'b0;
		rx_data = ~rx_data;
	endtask
endmodule // scpars_modem_model

//--- verif/scpars_parser_tb.sv
`include "scpars_defines.vh"
module scpars_parser_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {string m; logic [1:0] c; logic ok; string p;} scpars_row_t;
	logic        clk = 1'b0, rst = 1'b1, sel_modem = 1'b1, modem_rsp = 1'b0;
	logic [2:0]  cfg_pw_len = 3'h3;
	logic [55:0] cfg_pw = 56'h00_0000_0043_4241;
	wire         rx_valid, rx_last, found, par_v, done, ok, pw_given;
	wire [7:0]   rx_data, par_d;
	wire [1:0]   cls;
	wire [63:0]  cw;
	wire [3:0]   cl;
	int          errors = 0, checks = 0;
	string       got_p;
	scpars_row_t rows[6] = '{
		'{"pabc read x", `SCP_CLS_READ, 1'b1, "X"},
		'{"PXyz WRITE 1,2", `SCP_CLS_WRITE, 1'b0, ""},
		'{"CMD  STOP", `SCP_CLS_CMD, 1'b0, ""},
		'{"pAbc cmd  stop now", `SCP_CLS_CMD, 1'b1, "STOP NOW"},
		'{"Read", `SCP_CLS_READ, 1'b1, ""},
		'{"pabc FOO", `SCP_CLS_NONE, 1'b0, ""}};
	scpars_parser scpars_parser_inst (.clk(clk), .rst(rst),
		.sel_modem(sel_modem), .modem_rsp(modem_rsp), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_last(rx_last), .cfg_pw_len(cfg_pw_len),
		.cfg_pw(cfg_pw), .modem_found_q(found), .par_valid_q(par_v),
		.par_data_q(par_d), .msg_done_q(done), .msg_class_q(cls),
		.msg_ok_q(ok), .msg_pw_given_q(pw_given), .code_word_q(cw),
		.code_len_q(cl));
	scpars_modem_model scpars_modem_model_inst (.clk(clk),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last));
	// Clock and parameter capture
	always #10 clk = ~clk;
	always @(posedge clk)
		if (par_v === 1'b1) got_p = $sformatf("%s%c", got_p, par_d);
	task cmp_v(input string n, input logic [63:0] e, input logic [63:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task cmp_s(input string n, input string e, input string g);
		checks++;
		if (g != e) begin
			errors++;
			$display("ERROR %s expected %s seen %s", n, e, g);
		end
	endtask
	// Bounded wait for the verdict pulse
	task run(input string m);
		got_p = "";
		scpars_modem_model_inst.send(m);
		for (int k = 0; k < 8 && done !== 1'b1; k++) @(negedge clk);
	endtask
	task wrap_up;
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Table rows, then password, code length, reset and port cases
	initial begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		cmp_v("found", 8'h00, {7'h0, found});
		foreach (rows[i]) begin
			run(rows[i].m);
			cmp_v("done", 8'h01, {7'h0, done});
			cmp_v("class", {6'h0, rows[i].c}, {6'h0, cls});
			cmp_v("ok", {7'h0, rows[i].ok}, {7'h0, ok});
			if (rows[i].ok) cmp_s("param", rows[i].p, got_p);
		end
		run("pabcdefgh cmd");
		cmp_v("long", 8'h00, {7'h0, ok});
		cmp_v("pw_given", 8'h01, {7'h0, pw_given});
		cmp_v("code_len", 8'h03, {4'h0, cl});
		cmp_v("code_word", {40'h0, `SCP_KW_CMD}, cw);
		// Code longer than the store can never name an operation
		run("readwritex");
		cmp_v("overlong", {6'h0, `SCP_CLS_NONE}, {6'h0, cls});
		cmp_v("over_len", 8'h08, {4'h0, cl});
		cfg_pw_len = 3'h0;
		run("write 9");
		cmp_v("open", 8'h01, {7'h0, ok});
		cmp_v("no_pw", 8'h00, {7'h0, pw_given});
		// Reset in mid-run clears every verdict output
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		cmp_v("rst_class", 8'h00, {6'h0, cls});
		cmp_v("rst_ok", 8'h00, {7'h0, ok});
		cmp_v("rst_len", 8'h00, {4'h0, cl});
		sel_modem = 1'b0;
		run("read");
		cmp_v("off", 8'h00, {7'h0, done});
		sel_modem = 1'b1;
		modem_rsp = 1'b1;
		@(negedge clk);
		modem_rsp = 1'b0;
		cmp_v("found", 8'h01, {7'h0, found});
		wrap_up;
	end
	// Watchdog well beyond the roughly 130 cycles of traffic
	initial begin
		#50000;
		errors++;
		wrap_up;
	end
endmodule // scpars_parser_tb
